/* logic/crcscn_pkg.sv */
package crcscn_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_ACC = 8'h00;
   localparam logic [7:0] OFS_POLY = 8'h04;
   localparam logic [7:0] OFS_DATA_HI = 8'h08;
   localparam logic [7:0] OFS_DATA_LO = 8'h0C;
   localparam logic [7:0] OFS_CONFIG = 8'h10;
   localparam logic [7:0] OFS_CONTROL = 8'h14;
   localparam logic [7:0] OFS_SWEEP_CTL = 8'h18;
   localparam logic [7:0] OFS_SWEEP_START = 8'h1C;
   localparam logic [7:0] OFS_SWEEP_END = 8'h20;
   localparam logic [7:0] OFS_IRQ_FLAGS = 8'h24;
   localparam logic [7:0] OFS_IRQ_ENABLES = 8'h28;
   // Control register fields.
   localparam int CTL_GO = 0;
   localparam int CTL_BUSY = 1;
   localparam int CTL_FULL = 2;
   localparam int CTL_TZMODE = 3;
   localparam int CTL_SHIFT = 4;
   // Config register fields.
   localparam int CFG_POLY_LEN_LSB = 0;
   localparam int CFG_WORD_LEN_LSB = 4;
   // Sweep control fields.
   localparam int SWP_GO = 0;
   localparam int SWP_EN = 1;
   localparam int SWP_MODE_LSB = 2;
   localparam int SWP_IRQ_MODE_LSB = 4;
   // Flag register fields.
   localparam int IRQ_CRC = 0;
   localparam int IRQ_SWEEP = 1;
   localparam logic [1:0] MODE_BURST = 2'h1;
   localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      CRCSCN_IDLE = 2'b00,
      CRCSCN_SHIFT = 2'b01,
      CRCSCN_ZEROS = 2'b11
   } crcscn_state_t;

   typedef enum logic [1:0] {
      CRCSCN_SW_IDLE = 2'b00,
      CRCSCN_SW_WAIT = 2'b01,
      CRCSCN_SW_FETCH = 2'b11
   } crcscn_sweep_t;

   typedef struct packed {
      logic [3:0] word_length_minus_one;
      logic [3:0] poly_length_minus_two;
      logic trailing_zero_mode;
      logic shift_lsb;
   } crcscn_cfg_t;
endpackage : crcscn_pkg

/* logic/crcscn_top.sv */
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
// What this block does
// - Software may preload the 16-bit accumulator.
// - Polynomial register gives the feedback pattern.
// - Shift word_length_minus_one plus one bits per word.
// - Poly length minus two sets accumulator width.
// - Zero shifts appended only when trailing zero mode is off.
// - Shift direction picks MSB or LSB first.
// - Shifting starts only after checksum_go set.
// - Full bit shown; writers wait for zero.
// - Low data byte write starts the shift.
// - Scanner feeds words while sweep_go set.
// - Last word done clears busy, sets flag.
// - Disabling scanner resets state and clears sweep_go, keeps other registers.
// - Mode field takes four values; only burst mode has an effect.
// - Interrupt mode field held in sweep control.
// - Start and end addresses from registers.
// - Scanner waits for checksum_go before fetching.
// - End or unimplemented address stops the scan.
// - Software may clear sweep_go to abort.
// - Falling sweep_go raises the sweep interrupt.
// - Sweep flag cleared only by software.
// - Sweep interrupt gated by its enable bit.
// - Burst mode stalls the CPU while scanning.
module crcscn_top #(
   parameter int ADDR_W = 15,
   parameter int ACC_W = 16
) (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Program memory port.
   output logic mem_req,
   output logic [ADDR_W-1:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   input wire logic mem_unimpl,
   // System.
   output logic cpu_stall,
   output logic sweep_irq
);
   ////////////////////////////////////////////////////////////////////////
   // Bus decode.
   logic wr_pend_q, wr_pend_d, rd_pend_q, rd_pend_d;
   logic [7:0] wr_addr_q, wr_addr_d, rd_addr_q, rd_addr_d;
   logic [7:0] rd_addr;
   logic wr_now;

   // A read waits one cycle, so a write landing on its address edge is seen.
   always_comb begin
      wr_pend_d = hsel && hready && htrans[1] && hwrite;
      rd_pend_d = hsel && hready && htrans[1] && !hwrite;
      wr_addr_d = (hsel && hready && htrans[1]) ? haddr[7:0] : wr_addr_q;
      rd_addr_d = rd_pend_d ? haddr[7:0] : rd_addr_q;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rd_pend_q <= 1'b0;
         rd_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         rd_pend_q <= rd_pend_d;
         rd_addr_q <= rd_addr_d;
      end
   end

   assign wr_now = wr_pend_q;
   assign rd_addr = rd_addr_q;
   assign hreadyout = !rd_pend_q;
   assign hresp = 1'b0;

   function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs, input logic p);
      wr_hit = p && (a == ofs);
   endfunction : wr_hit

   ////////////////////////////////////////////////////////////////////////
   // Registers and engine state.
   logic [ACC_W-1:0] acc_q, acc_d, poly_q, poly_d, data_q, data_d, sh_q, sh_d;
   logic [7:0] hi_q, hi_d;
   crcscn_pkg::crcscn_cfg_t cfg_q, cfg_d;
   logic go_q, go_d, full_q, full_d, crc_if_q, crc_if_d;
   logic [4:0] cnt_q, cnt_d;
   crcscn_pkg::crcscn_state_t st_q, st_d;
   logic sg_q, sg_d, sen_q, sen_d, sif_q, sif_d, sie_q, sie_d;
   logic [1:0] smode_q, smode_d, sintm_q, sintm_d;
   logic [ADDR_W-1:0] sstart_q, sstart_d, send_q, send_d, sptr_q, sptr_d;
   crcscn_pkg::crcscn_sweep_t sw_q, sw_d;
   logic sweep_push, sweep_last, sg_fall;
   logic [15:0] width_mask;
   logic top_bit, in_bit, fb;
   logic [4:0] poly_top;
   logic busy, sif_clr;

   assign poly_top = 5'(cfg_q.poly_length_minus_two) + 5'h1;
   assign width_mask =
      16'((17'h1 << (6'(cfg_q.poly_length_minus_two) + 6'h2)) - 17'h1);
   assign busy = (st_q != crcscn_pkg::CRCSCN_IDLE) || (full_q && go_q);

   always_comb begin
      top_bit = acc_q[poly_top[3:0]];
      in_bit = (st_q == crcscn_pkg::CRCSCN_ZEROS) ? 1'b0 :
         (cfg_q.shift_lsb ? sh_q[0] : sh_q[cfg_q.word_length_minus_one]);
      fb = top_bit ^ (cfg_q.trailing_zero_mode ? in_bit : 1'b0);
   end

   always_comb begin
      acc_d = acc_q;
      poly_d = poly_q;
      data_d = data_q;
      hi_d = hi_q;
      cfg_d = cfg_q;
      go_d = go_q;
      full_d = full_q;
      crc_if_d = crc_if_q;
      cnt_d = cnt_q;
      st_d = st_q;
      sh_d = sh_q;
      // Register writes.
      if (wr_hit(wr_addr_q, crcscn_pkg::OFS_ACC, wr_now)) acc_d = hwdata[15:0];
      if (wr_hit(wr_addr_q, crcscn_pkg::OFS_POLY, wr_now)) poly_d = hwdata[15:0];
      if (wr_hit(wr_addr_q, crcscn_pkg::OFS_DATA_HI, wr_now)) hi_d = hwdata[7:0];
      if (wr_hit(wr_addr_q, crcscn_pkg::OFS_CONFIG, wr_now)) begin
         cfg_d.poly_length_minus_two = hwdata[crcscn_pkg::CFG_POLY_LEN_LSB +: 4];
         cfg_d.word_length_minus_one = hwdata[crcscn_pkg::CFG_WORD_LEN_LSB +: 4];
      end
      if (wr_hit(wr_addr_q, crcscn_pkg::OFS_CONTROL, wr_now)) begin
         go_d = hwdata[crcscn_pkg::CTL_GO];
         cfg_d.trailing_zero_mode = hwdata[crcscn_pkg::CTL_TZMODE];
         cfg_d.shift_lsb = hwdata[crcscn_pkg::CTL_SHIFT];
      end
      if (wr_hit(wr_addr_q, crcscn_pkg::OFS_IRQ_FLAGS, wr_now) && hwdata[crcscn_pkg::IRQ_CRC])
         crc_if_d = 1'b0;
      // Data word arrives on low byte write or from the scanner.
      if (sweep_push) begin
         data_d = mem_rdata;
         full_d = 1'b1;
      end else if (wr_hit(wr_addr_q, crcscn_pkg::OFS_DATA_LO, wr_now) && !full_q) begin
         data_d = {hi_q, hwdata[7:0]};
         full_d = 1'b1;
      end
      case (st_q)
         crcscn_pkg::CRCSCN_IDLE: begin
            if (go_q && full_q) begin
               sh_d = data_q;
               full_d = full_d && sweep_push;
               cnt_d = 5'(cfg_q.word_length_minus_one) + 5'h1;
               st_d = crcscn_pkg::CRCSCN_SHIFT;
            end
         end
         crcscn_pkg::CRCSCN_SHIFT, crcscn_pkg::CRCSCN_ZEROS: begin
            acc_d = (((acc_q << 1) | 16'(cfg_q.trailing_zero_mode ? 1'b0 : in_bit))
               ^ (fb ? poly_q : 16'h0000)) & width_mask;
            sh_d = cfg_q.shift_lsb ? (sh_q >> 1) : (sh_q << 1);
            cnt_d = cnt_q - 5'h1;
            if (cnt_q == 5'h1) begin
               if (full_q && go_q) begin
                  sh_d = data_q;
                  full_d = full_d && sweep_push;
                  cnt_d = 5'(cfg_q.word_length_minus_one) + 5'h1;
                  st_d = crcscn_pkg::CRCSCN_SHIFT;
               end else if (st_q == crcscn_pkg::CRCSCN_SHIFT && !cfg_q.trailing_zero_mode) begin
                  cnt_d = poly_top + 5'h1;
                  st_d = crcscn_pkg::CRCSCN_ZEROS;
               end else begin
                  crc_if_d = 1'b1;
                  st_d = crcscn_pkg::CRCSCN_IDLE;
               end
            end
         end
         default: st_d = crcscn_pkg::CRCSCN_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_q <= 16'h0000;
         poly_q <= 16'h0000;
         data_q <= 16'h0000;
         sh_q <= 16'h0000;
         hi_q <= 8'h00;
         cfg_q <= '0;
         go_q <= 1'b0;
         full_q <= 1'b0;
         crc_if_q <= 1'b0;
         cnt_q <= 5'h00;
         st_q <= crcscn_pkg::CRCSCN_IDLE;
      end else begin
         acc_q <= acc_d;
         poly_q <= poly_d;
         data_q <= data_d;
         sh_q <= sh_d;
         hi_q <= hi_d;
         cfg_q <= cfg_d;
         go_q <= go_d;
         full_q <= full_d;
         crc_if_q <= crc_if_d;
         cnt_q <= cnt_d;
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Memory scanner.
   assign sweep_push = (sw_q == crcscn_pkg::CRCSCN_SW_FETCH) && mem_ack && !mem_unimpl;
   assign sweep_last = sptr_q == send_q;
   assign sg_fall = sg_q && !sg_d;
   assign sif_clr = wr_hit(wr_addr_q, crcscn_pkg::OFS_IRQ_FLAGS, wr_now)
      && hwdata[crcscn_pkg::IRQ_SWEEP];

   always_comb begin
      sg_d = sg_q;
      sen_d = sen_q;
      smode_d = smode_q;
      sintm_d = sintm_q;
      sstart_d = sstart_q;
      send_d = send_q;
      sptr_d = sptr_q;
      sw_d = sw_q;
      sif_d = sif_q;
      sie_d = sie_q;
      if (wr_hit(wr_addr_q, crcscn_pkg::OFS_SWEEP_CTL, wr_now)) begin
         sg_d = hwdata[crcscn_pkg::SWP_GO];
         sen_d = hwdata[crcscn_pkg::SWP_EN];
         smode_d = hwdata[crcscn_pkg::SWP_MODE_LSB +: 2];
         sintm_d = hwdata[crcscn_pkg::SWP_IRQ_MODE_LSB +: 2];
      end
      if (wr_hit(wr_addr_q, crcscn_pkg::OFS_SWEEP_START, wr_now))
         sstart_d = hwdata[ADDR_W-1:0];
      if (wr_hit(wr_addr_q, crcscn_pkg::OFS_SWEEP_END, wr_now))
         send_d = hwdata[ADDR_W-1:0];
      if (wr_hit(wr_addr_q, crcscn_pkg::OFS_IRQ_ENABLES, wr_now))
         sie_d = hwdata[crcscn_pkg::IRQ_SWEEP];
      if (sif_clr) sif_d = 1'b0;
      case (sw_q)
         crcscn_pkg::CRCSCN_SW_IDLE: begin
            sptr_d = sstart_q;
            if (sg_q && sen_q) sw_d = crcscn_pkg::CRCSCN_SW_WAIT;
         end
         crcscn_pkg::CRCSCN_SW_WAIT: begin
            if (go_q && !full_q) sw_d = crcscn_pkg::CRCSCN_SW_FETCH;
         end
         crcscn_pkg::CRCSCN_SW_FETCH: begin
            if (mem_ack) begin
               if (mem_unimpl || sweep_last) begin
                  sg_d = 1'b0;
                  sw_d = crcscn_pkg::CRCSCN_SW_IDLE;
               end else begin
                  sptr_d = sptr_q + ADDR_W'(1);
                  sw_d = crcscn_pkg::CRCSCN_SW_WAIT;
               end
            end
         end
         default: sw_d = crcscn_pkg::CRCSCN_SW_IDLE;
      endcase
      if (!sen_d || !sg_d) sw_d = crcscn_pkg::CRCSCN_SW_IDLE;
      if (!sen_d) sg_d = 1'b0;
      if (sg_q && !sg_d) sif_d = 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sg_q <= 1'b0;
         sen_q <= 1'b0;
         smode_q <= 2'h0;
         sintm_q <= 2'h0;
         sstart_q <= '0;
         send_q <= '0;
         sptr_q <= '0;
         sw_q <= crcscn_pkg::CRCSCN_SW_IDLE;
         sif_q <= 1'b0;
         sie_q <= 1'b0;
      end else begin
         sg_q <= sg_d;
         sen_q <= sen_d;
         smode_q <= smode_d;
         sintm_q <= sintm_d;
         sstart_q <= sstart_d;
         send_q <= send_d;
         sptr_q <= sptr_d;
         sw_q <= sw_d;
         sif_q <= sif_d;
         sie_q <= sie_d;
      end
   end

   assign mem_req = sw_q == crcscn_pkg::CRCSCN_SW_FETCH;
   assign mem_addr = sptr_q;
   assign cpu_stall = sg_q && sen_q && (smode_q == crcscn_pkg::MODE_BURST);
   assign sweep_irq = sif_q && sie_q;

   ////////////////////////////////////////////////////////////////////////
   // Read data.
   logic [31:0] rd_d, rd_q;
   always_comb begin
      case (rd_addr)
         crcscn_pkg::OFS_ACC: rd_d = 32'(acc_q);
         crcscn_pkg::OFS_POLY: rd_d = 32'(poly_q);
         crcscn_pkg::OFS_DATA_HI: rd_d = 32'(hi_q);
         crcscn_pkg::OFS_DATA_LO: rd_d = 32'(data_q[7:0]);
         crcscn_pkg::OFS_CONFIG: rd_d = 32'({cfg_q.word_length_minus_one,
            cfg_q.poly_length_minus_two});
         crcscn_pkg::OFS_CONTROL: rd_d = 32'({cfg_q.shift_lsb, cfg_q.trailing_zero_mode,
            full_q, busy, go_q});
         crcscn_pkg::OFS_SWEEP_CTL: rd_d = 32'({sintm_q, smode_q, sen_q, sg_q});
         crcscn_pkg::OFS_SWEEP_START: rd_d = 32'(sstart_q);
         crcscn_pkg::OFS_SWEEP_END: rd_d = 32'(send_q);
         crcscn_pkg::OFS_IRQ_FLAGS: rd_d = 32'({sif_q, crc_if_q});
         crcscn_pkg::OFS_IRQ_ENABLES: rd_d = 32'({sie_q, 1'b0});
         default: rd_d = crcscn_pkg::RESET_ZERO;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) rd_q <= 32'h0000_0000;
      else if (rd_pend_q) rd_q <= rd_d;
   end
   assign hrdata = rd_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   a_sweep_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      sweep_irq == (sif_q && sie_q)) else $error("sweep irq not gated");
   a_fall_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(sg_q) |-> sif_q) else $error("sweep flag not set on fall");
   a_fall_flag_next: assert property (@(posedge hclk) disable iff (!hresetn)
      sg_fall |=> (sif_q && !sg_q)) else $error("sweep fall not flagged");
   a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(sif_q) |-> $past(sif_clr)) else $error("sweep flag cleared by hardware");
   a_no_shift_nogo: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_q == crcscn_pkg::CRCSCN_IDLE && !go_q) |=> st_q == crcscn_pkg::CRCSCN_IDLE)
      else $error("shift without go");
   a_fetch_needs_go: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(mem_req) |-> go_q) else $error("fetch before crc go");
   a_disable_idle: assert property (@(posedge hclk) disable iff (!hresetn)
      !sen_q |=> sw_q == crcscn_pkg::CRCSCN_SW_IDLE) else $error("scanner alive disabled");
   a_end_stops: assert property (@(posedge hclk) disable iff (!hresetn)
      (mem_req && mem_ack && sweep_last) |=> !sg_q) else $error("scan did not stop");
   a_burst_stall: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_hit(wr_addr_q, crcscn_pkg::OFS_SWEEP_CTL, wr_now) && hwdata[crcscn_pkg::SWP_GO]
      && hwdata[crcscn_pkg::SWP_EN]
      && hwdata[crcscn_pkg::SWP_MODE_LSB +: 2] == crcscn_pkg::MODE_BURST) |=> cpu_stall)
      else $error("burst not stalling");
endmodule : crcscn_top

/* testbench/crcscn_flash_model.sv */
`timescale 1ns/1ps
module crcscn_flash_model #(
   parameter int ADDR_W = 15,
   parameter int UNIMPL_FROM = 'h7000
) (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Memory port.
   input wire logic mem_req,
   input wire logic [ADDR_W-1:0] mem_addr,
   output logic mem_ack,
   output logic [15:0] mem_rdata,
   output logic mem_unimpl,
   // Answer delay in cycles.
   input wire logic [3:0] delay
);
   logic [3:0] wait_q;
   // Answers a request after the set delay; data toggles while not answering.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wait_q <= 4'h0;
         mem_ack <= 1'b0;
         mem_unimpl <= 1'b0;
         mem_rdata <= 16'h0000;
      end else begin
         mem_ack <= 1'b0;
         mem_unimpl <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack && wait_q >= delay) begin
            mem_ack <= 1'b1;
            mem_unimpl <= (32'(mem_addr) >= UNIMPL_FROM);
            mem_rdata <= 16'(mem_addr) ^ 16'h5A3C;
            wait_q <= 4'h0;
         end else if (mem_req && !mem_ack) begin
            wait_q <= wait_q + 4'h1;
         end
      end
   end
endmodule : crcscn_flash_model

/* testbench/crcscn_top_test.sv */
`timescale 1ns/1ps
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
   $display("Error %0t: got %h want %h", $time, (g), (e)); end end
module crcscn_top_test;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout, hresp, mem_req, mem_ack, mem_unimpl, cpu_stall, sweep_irq;
   logic [14:0] mem_addr;
   logic [15:0] mem_rdata;
   logic [3:0] delay = 4'h0;
   logic [31:0] rd;
   int mismatches = 0;
   int n_compared = 0;
   int n_acks = 0;
   crcscn_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .mem_unimpl(mem_unimpl), .cpu_stall(cpu_stall), .sweep_irq(sweep_irq));
   crcscn_flash_model i_flash (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .mem_unimpl(mem_unimpl), .delay(delay));
   always #50 hclk = ~hclk;
   always @(posedge hclk) if (mem_ack === 1'b1 && mem_unimpl === 1'b0) n_acks++;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      int n;
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      n = 0;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin mismatches++; $display("Error %0t: bus timed out", $time); end
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      n = 0;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin mismatches++; $display("Error %0t: bus timed out", $time); end
      rd = hrdata;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask : wr
   task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0000_0000);
      `CHECK(rd & m, e)
   endtask : rdm
   task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
      int n;
      n = 0;
      do begin xfer(a, 1'b0, 32'h0000_0000); n++; end while (rd[b] !== v && n < 400);
      if (n >= 400) begin mismatches++; $display("Error %0t: wait timed out", $time); end
   endtask : wait_bit
   function automatic logic [15:0] crc_ref(logic [15:0] acc, logic [15:0] poly,
         logic [15:0] d, int dl, int pl, logic tzm, logic lsb);
      logic [15:0] mask;
      logic b;
      logic fb;
      mask = 16'((17'h1 << (pl + 2)) - 17'h1);
      for (int i = 0; i <= dl + (tzm ? 0 : pl + 2); i++) begin
         b = (i > dl) ? 1'b0 : (lsb ? d[i] : d[dl - i]);
         fb = acc[pl + 1] ^ (tzm & b);
         acc = ((acc << 1) | 16'(b & !tzm)) & mask;
         if (fb) acc = acc ^ (poly & mask);
      end
      return acc;
   endfunction : crc_ref
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdm(crcscn_pkg::OFS_CONTROL, 32'h1F, 32'h0);
      rdm(crcscn_pkg::OFS_SWEEP_CTL, 32'h3F, 32'h0);
      rdm(crcscn_pkg::OFS_IRQ_FLAGS, 32'h3, 32'h0);
      wr(8'h3C, 32'hFFFF_FFFF);
      rdm(8'h3C, 32'hFFFF_FFFF, 32'h0);
      `CHECK({hresp, cpu_stall, sweep_irq}, 3'h0)
      $display("t_reset done");
   endtask : t_reset
   task automatic t_manual(input logic [15:0] seed, poly, d0, d1, input int nw, dl, pl,
         input logic tzm, lsb);
      logic [15:0] e;
      e = crc_ref(seed, poly, d0, dl, pl, tzm, lsb);
      if (nw > 1) e = crc_ref(e, poly, d1, dl, pl, tzm, lsb);
      wr(crcscn_pkg::OFS_ACC, 32'(seed));
      wr(crcscn_pkg::OFS_POLY, 32'(poly));
      wr(crcscn_pkg::OFS_CONFIG, 32'(dl * 16 + pl));
      wr(crcscn_pkg::OFS_CONTROL, 32'h1 | 32'(tzm) << 3 | 32'(lsb) << 4);
      wr(crcscn_pkg::OFS_DATA_HI, 32'(d0[15:8]));
      wr(crcscn_pkg::OFS_DATA_LO, 32'(d0[7:0]));
      rdm(crcscn_pkg::OFS_CONTROL, 32'h2, 32'h2);
      if (nw > 1) begin
         wait_bit(crcscn_pkg::OFS_CONTROL, crcscn_pkg::CTL_FULL, 1'b0);
         wr(crcscn_pkg::OFS_DATA_HI, 32'(d1[15:8]));
         wr(crcscn_pkg::OFS_DATA_LO, 32'(d1[7:0]));
      end
      wait_bit(crcscn_pkg::OFS_CONTROL, crcscn_pkg::CTL_BUSY, 1'b0);
      rdm(crcscn_pkg::OFS_IRQ_FLAGS, 32'h1, 32'h1);
      rdm(crcscn_pkg::OFS_ACC, 32'hFFFF, 32'(e));
      wr(crcscn_pkg::OFS_IRQ_FLAGS, 32'h1);
      rdm(crcscn_pkg::OFS_IRQ_FLAGS, 32'h1, 32'h0);
      $display("t_manual done");
   endtask : t_manual
   task automatic t_scan(input logic [14:0] lo, hi, input int nexp, input logic [3:0] dly);
      logic [15:0] e;
      int a0;
      e = 16'hFFFF;
      for (int a = lo; a < lo + nexp; a++) e = crc_ref(e, 16'h1021, 16'(a) ^ 16'h5A3C,
         15, 14, 1'b1, 1'b0);
      delay <= dly;
      a0 = n_acks;
      wr(crcscn_pkg::OFS_ACC, 32'hFFFF);
      wr(crcscn_pkg::OFS_POLY, 32'h1021);
      wr(crcscn_pkg::OFS_CONFIG, 32'hFE);
      wr(crcscn_pkg::OFS_CONTROL, 32'h9);
      wr(crcscn_pkg::OFS_SWEEP_START, 32'(lo));
      wr(crcscn_pkg::OFS_SWEEP_END, 32'(hi));
      wr(crcscn_pkg::OFS_SWEEP_CTL, 32'h17);
      @(negedge hclk);
      `CHECK(cpu_stall, 1'b1)
      @(posedge hclk);
      wait_bit(crcscn_pkg::OFS_SWEEP_CTL, crcscn_pkg::SWP_GO, 1'b0);
      `CHECK({cpu_stall, sweep_irq}, 2'b01)
      wait_bit(crcscn_pkg::OFS_CONTROL, crcscn_pkg::CTL_BUSY, 1'b0);
      `CHECK(n_acks - a0, nexp)
      rdm(crcscn_pkg::OFS_ACC, 32'hFFFF, 32'(e));
      wr(crcscn_pkg::OFS_IRQ_FLAGS, 32'h2);
      rdm(crcscn_pkg::OFS_IRQ_FLAGS, 32'h2, 32'h0);
      `CHECK(sweep_irq, 1'b0)
      $display("t_scan done");
   endtask : t_scan
   task automatic t_abort();
      int a0;
      wr(crcscn_pkg::OFS_CONTROL, 32'h0);
      wr(crcscn_pkg::OFS_IRQ_ENABLES, 32'h0);
      a0 = n_acks;
      wr(crcscn_pkg::OFS_SWEEP_CTL, 32'h3);
      repeat (20) @(posedge hclk);
      `CHECK(n_acks, a0)
      wr(crcscn_pkg::OFS_SWEEP_CTL, 32'h2);
      rdm(crcscn_pkg::OFS_IRQ_FLAGS, 32'h2, 32'h2);
      `CHECK(sweep_irq, 1'b0)
      wr(crcscn_pkg::OFS_IRQ_ENABLES, 32'h2);
      rdm(crcscn_pkg::OFS_IRQ_FLAGS, 32'h2, 32'h2);
      `CHECK(sweep_irq, 1'b1)
      for (int m = 0; m < 4; m++) begin
         wr(crcscn_pkg::OFS_SWEEP_CTL, 32'(2 + m * 4 + m * 16));
         rdm(crcscn_pkg::OFS_SWEEP_CTL, 32'h3E, 32'(2 + m * 4 + m * 16));
      end
      wr(crcscn_pkg::OFS_SWEEP_CTL, 32'h0);
      rdm(crcscn_pkg::OFS_SWEEP_START, 32'h7FFF, 32'h6FFE);
      $display("t_abort done");
   endtask : t_abort
   task automatic t_nogo();
      wr(crcscn_pkg::OFS_ACC, 32'h1234);
      wr(crcscn_pkg::OFS_DATA_HI, 32'h55);
      wr(crcscn_pkg::OFS_DATA_LO, 32'hAA);
      repeat (40) @(posedge hclk);
      rdm(crcscn_pkg::OFS_CONTROL, 32'h2, 32'h0);
      rdm(crcscn_pkg::OFS_ACC, 32'hFFFF, 32'h1234);
      $display("t_nogo done");
   endtask : t_nogo
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_manual(16'hFFFF, 16'h1021, 16'h3132, 16'h0, 1, 15, 14, 1'b0, 1'b0);
      t_manual(16'h0000, 16'h0007, 16'h00A5, 16'h003C, 2, 7, 6, 1'b1, 1'b1);
      t_manual(16'h1D0F, 16'h8005, 16'hBEEF, 16'h0102, 2, 15, 14, 1'b1, 1'b0);
      t_manual(16'h0005, 16'h0003, 16'h000B, 16'h0, 1, 3, 2, 1'b0, 1'b1);
      wr(crcscn_pkg::OFS_IRQ_ENABLES, 32'h2);
      t_scan(15'h0100, 15'h0103, 4, 4'h0);
      t_scan(15'h6FFE, 15'h7005, 2, 4'h3);
      t_abort();
      t_nogo();
      results();
   end
   initial begin
      #5_000_000;
      mismatches++;
      results();
   end
endmodule : crcscn_top_test
